/* File: hw/srbm_pkg.sv */
// constants for the supervisor reset and battery monitor
package srbm_pkg;
    // clock
    localparam int unsigned CLK_PERIOD_NS     = 4;
    localparam int unsigned CLK_HZ            = 250_000_000;
    // request filter widths in ns
    localparam int unsigned REJECT_WIDTH_NS   = 50;
    localparam int unsigned MIN_REQUEST_PULSE_WIDTH_NS = 200;
    // accept threshold sits between reject and accept widths
    localparam int unsigned ACCEPT_THRESH_NS  = 100;
    localparam int unsigned ACCEPT_THRESH_CYC =
        (ACCEPT_THRESH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // reset stretch after request release, in ms
    localparam int unsigned RELEASE_MIN_MS    = 40;
    localparam int unsigned RELEASE_MAX_MS    = 200;
    localparam int unsigned RESET_HOLD_MS     = 100;
    localparam int unsigned RESET_HOLD_CYC    = RESET_HOLD_MS * (CLK_HZ / 1000);
    // recovery window after supply return, in ms (at most 200)
    localparam int unsigned RECOVERY_WINDOW_MS  = 100;
    localparam int unsigned RECOVERY_WINDOW_CYC =
        RECOVERY_WINDOW_MS * (CLK_HZ / 1000);
    // periodic battery check interval, in hours
    localparam int unsigned CHECK_INTERVAL_H  = 24;
    localparam longint unsigned CHECK_INTERVAL_CYC =
        64'(CHECK_INTERVAL_H) * 64'd3600 * 64'(CLK_HZ);
    // counter widths
    localparam int unsigned FILT_W = 8;
    localparam int unsigned TMR_W  = 32;
    localparam int unsigned PER_W  = 48;
endpackage : srbm_pkg

/* File: hw/srbm_sync.sv */
// two-flop synchroniser for one pin
`timescale 1ns/1ns
module srbm_sync
    import srbm_pkg::*;
#(
    parameter logic RESET_VAL = 1'b1
) (
    input  wire logic ref_clk,  // clock
    input  wire logic rst_b,    // sync reset, low
    input  wire logic async_in, // pin level
    output logic      sync_out  // synchronised level
);
    logic meta_q;
    logic meta_d;
    logic sync_d;

    // next values
    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    // two stages
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            meta_q   <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta_q   <= meta_d;
            sync_out <= sync_d;
        end
    end
endmodule : srbm_sync

/* File: hw/srbm_timer.sv */
// loadable down counter with running flag
`timescale 1ns/1ns
module srbm_timer
    import srbm_pkg::*;
#(
    parameter int unsigned WIDTH = TMR_W
) (
    input  wire logic             ref_clk, // clock
    input  wire logic             rst_b,   // sync reset, low
    input  wire logic             load,    // restart count
    input  wire logic [WIDTH-1:0] count,   // cycles to run
    output logic                  running  // high while counting
);
    logic [WIDTH-1:0] cnt_q;
    logic [WIDTH-1:0] cnt_d;

    // next count
    always_comb begin
        cnt_d = cnt_q;
        if (load) begin
            cnt_d = count;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - WIDTH'(1);
        end
    end

    // counter register
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign running = (cnt_q != '0) || load;
endmodule : srbm_timer

/* File: hw/srbm_top.sv */
// supervisor: reset stretch, battery checks, power-fail flag
`timescale 1ns/1ns
module srbm_top
    import srbm_pkg::*;
#(
    parameter int unsigned HOLD_CYC = RESET_HOLD_CYC,          // reset stretch
    parameter int unsigned REC_CYC  = RECOVERY_WINDOW_CYC,     // recovery
    parameter longint unsigned PERIOD_CYC = CHECK_INTERVAL_CYC // check period
) (
    input  wire logic ref_clk,             // 250 MHz clock
    input  wire logic rst_b,               // sync reset, low
    input  wire logic ext_reset_request_n, // reset request pin
    input  wire logic supply_ok,           // supply above deselect_threshold
    input  wire logic battery_good,        // battery compare above 2.5 V
    input  wire logic power_fail_sense_in, // sense above sense_threshold
    output logic      reset_out_n,         // reset to host, low active
    output logic      battery_low_n_o,     // battery low pin output level
    output logic      battery_low_n_oe,    // battery low pin drive enable
    output logic      power_fail_flag_n,   // power-fail flag, low active
    output logic      check_strobe         // battery sample taken, pulse
);
    typedef enum logic [1:0] {
        SRBM_OFF,
        SRBM_RECOVER,
        SRBM_RUN
    } srbm_state_e;

    logic req_s;
    logic sup_s;
    logic bat_s;
    logic sense_s;

    // pin synchronisers
    srbm_sync #(.RESET_VAL(1'b1)) u_sync_req (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .async_in (ext_reset_request_n),
        .sync_out (req_s)
    );
    srbm_sync #(.RESET_VAL(1'b0)) u_sync_sup (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .async_in (supply_ok),
        .sync_out (sup_s)
    );
    srbm_sync #(.RESET_VAL(1'b1)) u_sync_bat (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .async_in (battery_good),
        .sync_out (bat_s)
    );
    srbm_sync #(.RESET_VAL(1'b0)) u_sync_sns (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .async_in (power_fail_sense_in),
        .sync_out (sense_s)
    );

    srbm_state_e         state_q;
    srbm_state_e         state_d;
    logic [FILT_W-1:0]   filt_q;
    logic [FILT_W-1:0]   filt_d;
    logic                req_hit_q;
    logic                req_hit_d;
    logic [PER_W-1:0]    per_q;
    logic [PER_W-1:0]    per_d;
    logic                bl_q;
    logic                bl_d;
    logic                rst_n_q;
    logic                rst_n_d;
    logic                pf_q;
    logic                pf_d;
    logic                chk_q;
    logic                chk_d;
    logic                hold_load;
    logic                hold_run;
    logic                rec_load;
    logic                rec_run;

    // stretch timer after request release
    srbm_timer #(.WIDTH(TMR_W)) u_hold (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .load    (hold_load),
        .count   (TMR_W'(HOLD_CYC)),
        .running (hold_run)
    );
    // recovery window after supply return
    srbm_timer #(.WIDTH(TMR_W)) u_rec (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .load    (rec_load),
        .count   (TMR_W'(REC_CYC)),
        .running (rec_run)
    );

    // request filter: count low cycles, accept past threshold
    always_comb begin
        filt_d    = filt_q;
        req_hit_d = req_hit_q;
        hold_load = 1'b0;
        if (!req_s && sup_s) begin
            if (filt_q != FILT_W'(ACCEPT_THRESH_CYC)) begin
                filt_d = filt_q + FILT_W'(1);
            end else begin
                req_hit_d = 1'b1;
            end
        end else begin
            filt_d = '0;
            if (req_hit_q) begin
                req_hit_d = 1'b0;
                hold_load = sup_s;
            end
        end
    end

    // supply state and recovery window
    always_comb begin
        state_d  = state_q;
        rec_load = 1'b0;
        unique case (state_q)
            SRBM_OFF: begin
                if (sup_s) begin
                    state_d  = SRBM_RECOVER;
                    rec_load = 1'b1;
                end
            end
            SRBM_RECOVER: begin
                if (!sup_s) begin
                    state_d = SRBM_OFF;
                end else if (!rec_run) begin
                    state_d = SRBM_RUN;
                end
            end
            SRBM_RUN: begin
                if (!sup_s) begin
                    state_d = SRBM_OFF;
                end
            end
        endcase
    end

    // battery checks at power-up and periodically
    always_comb begin
        per_d = per_q;
        bl_d  = bl_q;
        chk_d = 1'b0;
        if (state_q != SRBM_RUN) begin
            per_d = '0;
        end else if (per_q == '0 || per_q == PER_W'(PERIOD_CYC)) begin
            chk_d = 1'b1;
            bl_d  = !bat_s;
            per_d = PER_W'(1);
        end else begin
            per_d = per_q + PER_W'(1);
        end
    end

    // reset output and power-fail flag
    always_comb begin
        rst_n_d = !(state_q != SRBM_RUN || req_hit_q || hold_run
                    || hold_load);
        pf_d    = 1'b0;
        unique case (state_q)
            SRBM_OFF:     pf_d = 1'b0;
            SRBM_RECOVER: pf_d = 1'b1;
            SRBM_RUN:     pf_d = sense_s;
        endcase
    end

    // registers
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state_q   <= SRBM_OFF;
            filt_q    <= '0;
            req_hit_q <= 1'b0;
            per_q     <= '0;
            bl_q      <= 1'b0;
            rst_n_q   <= 1'b0;
            pf_q      <= 1'b0;
            chk_q     <= 1'b0;
        end else begin
            state_q   <= state_d;
            filt_q    <= filt_d;
            req_hit_q <= req_hit_d;
            per_q     <= per_d;
            bl_q      <= bl_d;
            rst_n_q   <= rst_n_d;
            pf_q      <= pf_d;
            chk_q     <= chk_d;
        end
    end

    assign reset_out_n       = rst_n_q;
    assign battery_low_n_o   = 1'b0;
    assign battery_low_n_oe  = bl_q;
    assign power_fail_flag_n = pf_q;
    assign check_strobe      = chk_q;

    logic [TMR_W-1:0]    since_q;
    logic [TMR_W-1:0]    since_d;

    // assertion helper: cycles since the last hold load, saturating
    always_comb begin
        since_d = since_q;
        if (hold_load) begin
            since_d = TMR_W'(1);
        end else if (since_q != '1) begin
            since_d = since_q + TMR_W'(1);
        end
    end

    // helper register, starts saturated so power-up releases pass
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            since_q <= '1;
        end else begin
            since_q <= since_d;
        end
    end

    // flag assertions
    a_flag_backup_low: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (state_q == SRBM_OFF) |=> !power_fail_flag_n)
        else $error("flag not low in backup");
    a_flag_recover_hi: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (state_q == SRBM_RECOVER) |=> power_fail_flag_n)
        else $error("flag not high in recovery");
    a_flag_tracks: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (state_q == SRBM_RUN) |=> (power_fail_flag_n == $past(sense_s)))
        else $error("flag does not track sense");

    // reset assertions
    a_reset_in_recover: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (state_q != SRBM_RUN) |=> !reset_out_n)
        else $error("reset released before recovery end");
    a_short_pulse_ign: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (state_q == SRBM_RUN && sup_s && !hold_run && !req_hit_q && req_s
         && $past(req_s) && $past(req_s, 2)) ##1 (!req_s && sup_s)
        ##1 (req_s && sup_s) |=> ##1 reset_out_n)
        else $error("short request pulse gave reset");
    a_long_pulse_rst: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (!req_s && sup_s)[*8] ##1 (!req_s && sup_s && filt_q ==
         FILT_W'(ACCEPT_THRESH_CYC)) |=> ##1 !reset_out_n)
        else $error("long request gave no reset");
    a_hold_after_rel: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        hold_load |=> !reset_out_n [*8])
        else $error("reset not held after release");
    a_hold_min_len: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        $rose(reset_out_n) |-> (since_q >= TMR_W'(HOLD_CYC)))
        else $error("reset released too soon after request");

    // battery assertions
    a_bl_opendrain: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        battery_low_n_oe |-> !battery_low_n_o)
        else $error("battery low drives high");
    a_bl_sticky: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (!chk_d && $past(rst_b)) |=> (bl_q == $past(bl_q)))
        else $error("battery low changed without check");
    a_no_check_off: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        (state_q != SRBM_RUN) |=> !check_strobe)
        else $error("check outside nominal supply");
    a_check_result: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        chk_d |=> (battery_low_n_oe == $past(!bat_s)))
        else $error("check result not applied");
    a_strobe_single: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        check_strobe |=> !check_strobe)
        else $error("check strobe longer than one cycle");

    c_ext_reset: cover property (@(posedge ref_clk) disable iff (!rst_b)
        hold_load ##1 hold_run);
    c_power_up: cover property (@(posedge ref_clk) disable iff (!rst_b)
        state_q == SRBM_RECOVER ##1 state_q == SRBM_RUN);
    c_bat_low: cover property (@(posedge ref_clk) disable iff (!rst_b)
        $rose(battery_low_n_oe));
    c_pf_low: cover property (@(posedge ref_clk) disable iff (!rst_b)
        state_q == SRBM_RUN && $fell(power_fail_flag_n));
    c_short_glitch: cover property (@(posedge ref_clk) disable iff (!rst_b)
        req_s ##1 !req_s ##1 req_s);
endmodule : srbm_top

/* File: bench/srbm_host.sv */
// host model: reset input, power-fail interrupt, pulled-up battery line
`timescale 1ns/1ns
module srbm_host (
    input  wire logic ref_clk,           // clock
    input  wire logic rst_b,             // sync reset, low
    input  wire logic reset_out_n,       // reset from supervisor
    input  wire logic power_fail_flag_n, // power-fail interrupt
    input  wire logic battery_low_n_o,   // battery low drive level
    input  wire logic battery_low_n_oe,  // battery low drive enable
    output logic      battery_low_n,     // resolved pin level
    output int        reset_count        // host resets seen
);
    logic rst_q;
    // pull-up gives the high level unless the pin is pulled low
    assign battery_low_n = battery_low_n_oe ? battery_low_n_o : 1'b1;
    // count each fall of the host reset
    always @(posedge ref_clk) begin
        rst_q <= reset_out_n;
        if (!rst_b) begin
            reset_count <= 0;
        end else if (rst_q && !reset_out_n) begin
            reset_count <= reset_count + 1;
        end
    end
endmodule : srbm_host

/* File: bench/srbm_top_tb.sv */
// self-checking bench for the supervisor top
`timescale 1ns/1ns
module srbm_top_tb;
    import srbm_pkg::*;
    localparam int HOLD = 50;
    localparam int REC  = 40;
    localparam int PER  = 200;
    logic ref_clk;
    logic rst_b;
    logic ext_reset_request_n;
    logic supply_ok;
    logic battery_good;
    logic power_fail_sense_in;
    logic reset_out_n;
    logic battery_low_n_o;
    logic battery_low_n_oe;
    logic power_fail_flag_n;
    logic check_strobe;
    logic battery_low_n;
    int   reset_count;
    int   fail_count = 0;
    int   compares = 0;
    int   cycles = 0;

    // design under test with short counts
    srbm_top #(.HOLD_CYC(HOLD), .REC_CYC(REC), .PERIOD_CYC(PER)) srbm_top_i (
        .ref_clk(ref_clk), .rst_b(rst_b),
        .ext_reset_request_n(ext_reset_request_n),
        .supply_ok(supply_ok), .battery_good(battery_good),
        .power_fail_sense_in(power_fail_sense_in),
        .reset_out_n(reset_out_n), .battery_low_n_o(battery_low_n_o),
        .battery_low_n_oe(battery_low_n_oe),
        .power_fail_flag_n(power_fail_flag_n),
        .check_strobe(check_strobe));

    // host side
    srbm_host srbm_host_i (
        .ref_clk(ref_clk), .rst_b(rst_b), .reset_out_n(reset_out_n),
        .power_fail_flag_n(power_fail_flag_n),
        .battery_low_n_o(battery_low_n_o),
        .battery_low_n_oe(battery_low_n_oe),
        .battery_low_n(battery_low_n), .reset_count(reset_count));

    // 250 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic test_done;
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done

    // hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            test_done;
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic chk_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit

    function automatic logic sig(input int sel);
        return (sel == 0) ? reset_out_n : check_strobe;
    endfunction : sig

    task automatic wait_sig(input int sel, input int lim, output int n);
        n = 0;
        while (n < lim && sig(sel) !== 1'b1) begin
            tick(1);
            n++;
        end
    endtask : wait_sig

    // supply return: forced flag, held reset, power-up check
    task automatic t_power_up(input logic bg);
        int n;
        battery_good = bg;
        supply_ok = 1'b1;
        tick(8);
        chk_bit(power_fail_flag_n, 1'b1);
        chk_bit(reset_out_n, 1'b0);
        wait_sig(0, REC + 20, n);
        chk_bit(n + 8 >= REC && reset_out_n === 1'b1, 1'b1);
        tick(3);
        chk_bit(power_fail_flag_n, 1'b0);
        chk_bit(battery_low_n, bg);
        $display("test power up done");
    endtask : t_power_up

    // flag follows the sense compare
    task automatic t_sense;
        power_fail_sense_in = 1'b1;
        tick(5);
        chk_bit(power_fail_flag_n, 1'b1);
        power_fail_sense_in = 1'b0;
        tick(5);
        chk_bit(power_fail_flag_n, 1'b0);
        $display("test sense done");
    endtask : t_sense

    // 40 ns and 4 ns glitches, then a 200 ns request
    task automatic t_request;
        int c;
        int n;
        c = reset_count;
        ext_reset_request_n = 1'b0;
        tick(10);
        ext_reset_request_n = 1'b1;
        tick(60);
        chk_bit(reset_out_n, 1'b1);
        ext_reset_request_n = 1'b0;
        tick(1);
        ext_reset_request_n = 1'b1;
        tick(10);
        chk_bit(reset_out_n, 1'b1);
        ext_reset_request_n = 1'b0;
        tick(50);
        ext_reset_request_n = 1'b1;
        chk_bit(reset_out_n, 1'b0);
        wait_sig(0, HOLD + 20, n);
        chk_bit(n >= HOLD && n <= HOLD + 10, 1'b1);
        chk_bit(reset_count == c + 1, 1'b1);
        $display("test request done");
    endtask : t_request

    // low flag holds until a periodic check, interval kept
    task automatic t_battery;
        int n;
        wait_sig(1, PER + 20, n);
        chk_bit(check_strobe, 1'b1);
        battery_good = 1'b1;
        tick(20);
        chk_bit(battery_low_n, 1'b0);
        wait_sig(1, PER + 20, n);
        chk_bit(n + 20 == PER, 1'b1);
        chk_bit(battery_low_n, 1'b1);
        battery_good = 1'b0;
        tick(1);
        wait_sig(1, PER + 20, n);
        chk_bit(n + 1 == PER, 1'b1);
        chk_bit(battery_low_n, 1'b0);
        chk_bit(battery_low_n_o, 1'b0);
        $display("test battery done");
    endtask : t_battery

    // backup: flag low, no checks, requests ignored
    task automatic t_backup;
        int k;
        k = 0;
        supply_ok = 1'b0;
        battery_good = 1'b1;
        power_fail_sense_in = 1'b1;
        tick(6);
        chk_bit(power_fail_flag_n, 1'b0);
        chk_bit(reset_out_n, 1'b0);
        ext_reset_request_n = 1'b0;
        repeat (300) begin
            tick(1);
            k += int'(check_strobe === 1'b1);
        end
        ext_reset_request_n = 1'b1;
        power_fail_sense_in = 1'b0;
        chk_bit(k == 0, 1'b1);
        chk_bit(battery_low_n, 1'b0);
        chk_bit(power_fail_flag_n, 1'b0);
        $display("test backup done");
    endtask : t_backup

    // main sequence
    initial begin
        rst_b = 1'b0;
        ext_reset_request_n = 1'b1;
        supply_ok = 1'b0;
        battery_good = 1'b0;
        power_fail_sense_in = 1'b0;
        repeat (16) @(posedge ref_clk);
        #1;
        rst_b = 1'b1;
        tick(2);
        t_power_up(1'b0);
        t_sense;
        t_request;
        t_battery;
        t_backup;
        t_power_up(1'b1);
        test_done;
    end
endmodule : srbm_top_tb
